// >>> core/io_space_address_decode.sv
// Purpose: peripheral register space decoder with bit access and store registers
// Assumes: core issues at most one access per cycle as a one-cycle strobe
// Notes: peripheral registers outside the store registers live in their blocks
`timescale 1ns/1ps
module io_space_address_decode (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic access_valid,
  input wire io_space_pkg::access_cmd_type access_cmd,
  input wire logic [7:0] access_addr,
  input wire logic [2:0] access_bit,
  input wire logic access_skip_if_set,
  input wire logic [7:0] access_wdata,
  input wire logic [7:0] periph_rdata,
  output logic [7:0] rdata_reg,
  output logic rdata_valid_reg,
  output logic skip_reg,
  output logic [7:0] periph_addr_reg,
  output logic [7:0] periph_wdata_reg,
  output logic [7:0] periph_w1c_mask_reg,
  output logic periph_write_reg,
  output logic periph_read_reg,
  output logic ext_write_reg,
  output logic ext_read_reg
);
  // ****************************************
  // decode and store registers
  // ****************************************
  logic [7:0] io_addr;
  logic io_hit;
  logic ext_hit;
  logic bit_ok;
  logic [7:0] store_0_reg;
  logic [7:0] store_1_reg;
  logic [7:0] store_2_reg;
  logic [7:0] store_3_reg;
  logic [7:0] bit_mask;
  logic is_store;
  logic [7:0] store_value;
  logic is_write;
  logic is_read;
  logic is_bitop;
  logic [7:0] new_value;
  logic is_ext_store;
  logic is_ext_load;
  logic is_test;
  logic is_load_cmd;

  io_addr_decode u_decode (
    .cmd(access_cmd),
    .addr(access_addr),
    .io_addr(io_addr),
    .io_hit(io_hit),
    .ext_hit(ext_hit),
    .bit_ok(bit_ok)
  );

  // one-hot mask of the chosen bit
  function automatic logic [7:0] onehot(input logic [2:0] b);
    onehot = io_space_pkg::bit_one << b;
  endfunction

  // read of a store register, zero elsewhere
  function automatic logic [7:0] store_read(input logic [7:0] a, input logic [7:0] s0,
      input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] s3);
    case (a)
      io_space_pkg::store_0_addr: store_read = s0;
      io_space_pkg::store_1_addr: store_read = s1;
      io_space_pkg::store_2_addr: store_read = s2;
      io_space_pkg::store_3_addr: store_read = s3;
      default: store_read = io_space_pkg::data_zero;
    endcase
  endfunction

  // chosen bit for a set-bit op, nothing for a clear-bit op
  function automatic logic [7:0] set_only(input io_space_pkg::access_cmd_type c, input logic [7:0] m);
    set_only = (c == io_space_pkg::cmd_set_bit) ? m : io_space_pkg::data_zero;
  endfunction

  // true when the tested bit matches the requested skip polarity
  function automatic logic bit_matches(input logic [7:0] value, input logic [7:0] m, input logic if_set);
    bit_matches = ((value & m) != io_space_pkg::data_zero) == if_set;
  endfunction

  // classify access
  always_comb begin
    bit_mask = onehot(access_bit);
    is_store = (io_addr == io_space_pkg::store_0_addr) || (io_addr == io_space_pkg::store_1_addr) ||
      (io_addr == io_space_pkg::store_2_addr) || (io_addr == io_space_pkg::store_3_addr);
    store_value = store_read(io_addr, store_0_reg, store_1_reg, store_2_reg, store_3_reg);
    is_write = access_valid && io_hit &&
      ((access_cmd == io_space_pkg::cmd_port_out) || (access_cmd == io_space_pkg::cmd_data_store));
    is_read = access_valid && io_hit &&
      ((access_cmd == io_space_pkg::cmd_port_in) || (access_cmd == io_space_pkg::cmd_data_load));
    is_bitop = access_valid && bit_ok &&
      ((access_cmd == io_space_pkg::cmd_set_bit) || (access_cmd == io_space_pkg::cmd_clear_bit));
    is_ext_store = access_valid && ext_hit && (access_cmd == io_space_pkg::cmd_data_store);
    is_ext_load = access_valid && ext_hit && (access_cmd == io_space_pkg::cmd_data_load);
    is_test = access_valid && bit_ok && (access_cmd == io_space_pkg::cmd_test_bit);
    is_load_cmd = access_valid &&
      ((access_cmd == io_space_pkg::cmd_port_in) || (access_cmd == io_space_pkg::cmd_data_load));
    // only the chosen bit changes in a bit operation
    if (access_cmd == io_space_pkg::cmd_set_bit) begin
      new_value = store_value | bit_mask;
    end else begin
      new_value = store_value & ~bit_mask;
    end
  end

  // ****************************************
  // general purpose store registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      store_0_reg <= io_space_pkg::store_reset;
      store_1_reg <= io_space_pkg::store_reset;
      store_2_reg <= io_space_pkg::store_reset;
      store_3_reg <= io_space_pkg::store_reset;
    end else if ((is_write || is_bitop) && is_store) begin
      case (io_addr)
        io_space_pkg::store_0_addr: store_0_reg <= is_write ? access_wdata : new_value;
        io_space_pkg::store_1_addr: store_1_reg <= is_write ? access_wdata : new_value;
        io_space_pkg::store_2_addr: store_2_reg <= is_write ? access_wdata : new_value;
        io_space_pkg::store_3_addr: store_3_reg <= is_write ? access_wdata : new_value;
        default: store_0_reg <= store_0_reg;
      endcase
    end
  end

  // ****************************************
  // forwarding to peripheral blocks
  // ****************************************
  // write and read strobes towards the io peripheral blocks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_write_reg <= 1'b0;
      periph_read_reg <= 1'b0;
    end else begin
      periph_write_reg <= (is_write || is_bitop) && !is_store;
      periph_read_reg <= is_read && !is_store;
    end
  end

  // extended range strobes, raised by data load and store only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_write_reg <= 1'b0;
      ext_read_reg <= 1'b0;
    end else begin
      ext_write_reg <= is_ext_store;
      ext_read_reg <= is_ext_load;
    end
  end

  // extended accesses keep the raw data address, io accesses the io address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_addr_reg <= io_space_pkg::data_zero;
    end else begin
      periph_addr_reg <= ext_hit ? access_addr : io_addr;
    end
  end

  // set-bit ops forward a one-hot mask, clear-bit ops forward zero; peripherals see it as a plain byte write with no bit index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_wdata_reg <= io_space_pkg::data_zero;
    end else if (is_bitop) begin
      periph_wdata_reg <= set_only(access_cmd, bit_mask);
    end else begin
      periph_wdata_reg <= access_wdata;
    end
  end

  // write-one-to-clear mask; a clear-bit op never asks to clear a flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periph_w1c_mask_reg <= io_space_pkg::data_zero;
    end else if (is_bitop) begin
      periph_w1c_mask_reg <= set_only(access_cmd, bit_mask);
    end else begin
      periph_w1c_mask_reg <= access_wdata;
    end
  end

  // ****************************************
  // read data and skip
  // ****************************************
  // an answer follows every port-in or data load, refused or not
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_valid_reg <= 1'b0;
    end else begin
      rdata_valid_reg <= is_load_cmd;
    end
  end

  // store register, io peripheral or extended peripheral data, zero elsewhere
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= io_space_pkg::data_zero;
    end else if (is_store) begin
      rdata_reg <= store_value;
    end else if (is_read || is_ext_load) begin
      rdata_reg <= periph_rdata;
    end else begin
      rdata_reg <= io_space_pkg::data_zero;
    end
  end

  // skip answer of a bit test, polarity chosen by the request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_reg <= 1'b0;
    end else if (is_test && is_store) begin
      skip_reg <= bit_matches(store_value, bit_mask, access_skip_if_set);
    end else if (is_test) begin
      skip_reg <= bit_matches(periph_rdata, bit_mask, access_skip_if_set);
    end else begin
      skip_reg <= 1'b0;
    end
  end
endmodule // io_space_address_decode

// >>> core/io_space_pkg.sv
// Purpose: constants for the peripheral register space address decoder
// Assumes: 8-bit data, single clock, asynchronous active-low reset
// Notes: data-space addresses are 8 bits wide; io addresses are 6 bits
//
// Behaviour
// - port in/out instructions decode only io addresses 0x00 to 0x3F.
// - low io registers appear in data space at io address plus 0x20.
// - extended range 0x60 to 0xFF reachable only by data load and store.
// - single-bit set and clear work on io addresses 0x00 to 0x1F only.
// - bit-accessible registers support skip-if-bit-set and skip-if-bit-clear tests.
// - some status flags clear when written one; writing zero leaves them.
// - bit set or clear touches only the chosen bit, never writes neighbours; kept for store registers only, peripherals get a whole-byte write.
package io_space_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [7:0] io_last_addr = 8'h3f;
  localparam logic [7:0] data_io_offset = 8'h20;
  localparam logic [7:0] ext_first_addr = 8'h60;
  localparam logic [7:0] ext_last_addr = 8'hff;
  localparam logic [7:0] bit_last_addr = 8'h1f;
  localparam logic [7:0] store_1_addr = 8'h19;
  localparam logic [7:0] store_2_addr = 8'h1a;
  localparam logic [7:0] store_3_addr = 8'h1b;
  localparam logic [7:0] store_0_addr = 8'h1e;
  localparam logic [7:0] store_reset = 8'h00;
  localparam logic [7:0] data_zero = 8'h00;
  localparam logic [7:0] bit_one = 8'h01;

  // ****************************************
  // access commands
  // ****************************************
  typedef enum logic [2:0] {
    cmd_none = 3'b000,
    cmd_port_in = 3'b001,
    cmd_port_out = 3'b010,
    cmd_data_load = 3'b011,
    cmd_data_store = 3'b100,
    cmd_set_bit = 3'b101,
    cmd_clear_bit = 3'b110,
    cmd_test_bit = 3'b111
  } access_cmd_type;
endpackage

// >>> core/io_addr_decode.sv
// Purpose: turns a command and address into an io register index
// Assumes: combinational, same clock domain as caller
// Notes: flags which access kinds the address permits
`timescale 1ns/1ps
module io_addr_decode (
  input wire io_space_pkg::access_cmd_type cmd,
  input wire logic [7:0] addr,
  output logic [7:0] io_addr,
  output logic io_hit,
  output logic ext_hit,
  output logic bit_ok
);
  // ****************************************
  // decode
  // ****************************************
  // io form is taken as given, data form has the offset removed
  always_comb begin
    io_addr = addr;
    io_hit = 1'b0;
    ext_hit = 1'b0;
    bit_ok = 1'b0;
    case (cmd)
      io_space_pkg::cmd_port_in, io_space_pkg::cmd_port_out: begin
        io_hit = (addr <= io_space_pkg::io_last_addr);
      end
      io_space_pkg::cmd_data_load, io_space_pkg::cmd_data_store: begin
        io_addr = addr - io_space_pkg::data_io_offset;
        io_hit = (addr >= io_space_pkg::data_io_offset) && (addr < io_space_pkg::ext_first_addr);
        ext_hit = (addr >= io_space_pkg::ext_first_addr);
      end
      io_space_pkg::cmd_set_bit, io_space_pkg::cmd_clear_bit, io_space_pkg::cmd_test_bit: begin
        bit_ok = (addr <= io_space_pkg::bit_last_addr);
        io_hit = bit_ok;
      end
      default: begin
        io_hit = 1'b0;
      end
    endcase
  end
endmodule // io_addr_decode

// >>> tb/io_space_properties.sv
// Purpose: port checks for the io space decoder
// Assumes: answers come one cycle after the request
// Notes: bound into every decoder instance
`timescale 1ns/1ps
module io_space_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic access_valid,
  input wire io_space_pkg::access_cmd_type access_cmd,
  input wire logic [7:0] access_addr,
  input wire logic [2:0] access_bit,
  input wire logic [7:0] periph_rdata,
  input wire logic [7:0] rdata_reg,
  input wire logic rdata_valid_reg,
  input wire logic skip_reg,
  input wire logic [7:0] periph_addr_reg,
  input wire logic [7:0] periph_wdata_reg,
  input wire logic [7:0] periph_w1c_mask_reg,
  input wire logic periph_write_reg,
  input wire logic periph_read_reg,
  input wire logic ext_write_reg,
  input wire logic ext_read_reg
);
  // ***
  // request decode and checks
  // ***
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic p_in = access_valid && access_cmd == io_space_pkg::cmd_port_in;
  wire logic load = access_valid && access_cmd == io_space_pkg::cmd_data_load;
  wire logic bset = access_valid && access_cmd == io_space_pkg::cmd_set_bit;
  wire logic bclr = access_valid && access_cmd == io_space_pkg::cmd_clear_bit;
  wire logic tst = access_valid && access_cmd == io_space_pkg::cmd_test_bit;
  wire logic p_out = access_valid && access_cmd == io_space_pkg::cmd_port_out;
  wire logic dstore = access_valid && access_cmd == io_space_pkg::cmd_data_store;
  // bit-range peripheral address, store registers excluded
  wire logic pa = access_addr <= 8'h1f && !(access_addr inside {8'h19, 8'h1a, 8'h1b, 8'h1e});
  a_port_in_answer: assert property (p_in |=> rdata_valid_reg)
    else $error("port read not answered");
  a_port_in_range: assert property (p_in && access_addr > 8'h3f |=> rdata_reg == 8'h00 && !periph_read_reg)
    else $error("port read out of range");
  a_ext_by_load: assert property (load && access_addr >= 8'h60 |=> ext_read_reg && periph_addr_reg == $past(access_addr))
    else $error("extended load lost");
  a_load_offset: assert property (load && access_addr inside {[8'h40:8'h5f]} |=>
    periph_read_reg && periph_addr_reg == $past(access_addr) - 8'h20)
    else $error("data offset wrong");
  a_ext_by_store: assert property (dstore && access_addr >= 8'h60 |=>
    ext_write_reg && !periph_write_reg && periph_addr_reg == $past(access_addr))
    else $error("extended store lost");
  a_ext_load_data: assert property (load && access_addr >= 8'h60 |=> rdata_reg == $past(periph_rdata))
    else $error("extended load data lost");
  a_port_out_range: assert property (p_out && access_addr > 8'h3f |=> !periph_write_reg && !ext_write_reg)
    else $error("port write out of range");
  a_bit_range: assert property ((bset || bclr) && access_addr > 8'h1f |=> !periph_write_reg)
    else $error("bit op out of range");
  a_set_one_bit: assert property (bset && pa |=> periph_write_reg && periph_wdata_reg == 8'h01 << $past(access_bit)
    && periph_w1c_mask_reg == periph_wdata_reg)
    else $error("set touched other bits");
  a_clear_no_ones: assert property (bclr && pa |=> periph_write_reg && periph_wdata_reg == 8'h00 && periph_w1c_mask_reg == 8'h00)
    else $error("clear wrote ones");
  a_skip_needs_test: assert property (!tst |=> !skip_reg)
    else $error("skip without test");
endmodule // io_space_properties
bind io_space_address_decode io_space_properties chk (.clk, .reset_n, .access_valid, .access_cmd, .access_addr,
  .access_bit, .periph_rdata, .rdata_reg, .rdata_valid_reg, .skip_reg, .periph_addr_reg, .periph_wdata_reg,
  .periph_w1c_mask_reg, .periph_write_reg, .periph_read_reg, .ext_write_reg, .ext_read_reg);

// >>> tb/core_model.sv
// Purpose: processor core model issuing io and data accesses
// Assumes: callers enter issue at a rising edge
// Notes: valid stays up across back-to-back calls; idle drops it
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  output logic access_valid,
  output io_space_pkg::access_cmd_type access_cmd,
  output logic [7:0] access_addr,
  output logic [2:0] access_bit,
  output logic access_skip_if_set,
  output logic [7:0] access_wdata
);
  // ***
  // access driver
  // ***
  initial begin
    access_cmd = io_space_pkg::cmd_none;
    {access_valid, access_addr, access_bit, access_skip_if_set, access_wdata} = '0;
  end
  // one access per cycle, to whatever address and data the caller gives
  task automatic issue(input io_space_pkg::access_cmd_type c, input logic [7:0] a, input logic [2:0] b,
    input logic p, input logic [7:0] d);
    access_cmd <= c;
    {access_valid, access_addr, access_bit, access_skip_if_set, access_wdata} <= {1'b1, a, b, p, d};
    @(posedge clk);
  endtask
  task automatic idle;
    access_valid <= 1'b0;
    @(posedge clk);
  endtask
endmodule // core_model

// >>> tb/io_space_address_decode_bench.sv
// Purpose: self-checking bench for the io space decoder
// Assumes: the core model issues one access per cycle
// Notes: the issuer queues answers, a monitor checks them
`timescale 1ns/1ps
`define check(what, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", what, exp, got); end end
module io_space_address_decode_bench;
  logic clk;
  logic reset_n;
  logic access_valid;
  io_space_pkg::access_cmd_type access_cmd;
  logic [7:0] access_addr;
  logic [2:0] access_bit;
  logic access_skip_if_set;
  logic [7:0] access_wdata;
  logic [7:0] rdata_reg;
  logic rdata_valid_reg;
  logic skip_reg;
  logic t_d;
  logic [7:0] e;
  logic [2:0] b;
  logic [7:0] v [4];
  logic [7:0] sa [4] = '{8'h19, 8'h1a, 8'h1b, 8'h1e};
  logic [7:0] exp_q [$];
  int compares = 0;
  int n_mismatch = 0;
  int cyc = 0;
  // peripherals answer with a pattern of the low address bits
  wire logic [7:0] periph_rdata = {3'b101, access_addr[4:0]};
  core_model core (.clk, .access_valid, .access_cmd, .access_addr, .access_bit, .access_skip_if_set, .access_wdata);
  io_space_address_decode dut (.clk, .reset_n, .access_valid, .access_cmd, .access_addr, .access_bit,
    .access_skip_if_set, .access_wdata, .periph_rdata, .rdata_reg, .rdata_valid_reg, .skip_reg,
    .periph_addr_reg(), .periph_wdata_reg(), .periph_w1c_mask_reg(), .periph_write_reg(),
    .periph_read_reg(), .ext_write_reg(), .ext_read_reg());
  // ***
  // clock, monitor and closing
  // ***
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic wrap_up;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // compares every read answer and every bit test with the oldest note
  always @(posedge clk) begin
    t_d <= access_valid && access_cmd == io_space_pkg::cmd_test_bit;
    cyc <= cyc + 1;
    if (rdata_valid_reg === 1'b1 || t_d === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `check("answer", e, rdata_valid_reg ? rdata_reg : {7'h00, skip_reg})
    end
    if (cyc == 400) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic go(input io_space_pkg::access_cmd_type c, input logic [7:0] a, input logic p,
    input logic [7:0] d, input int note, input logic [7:0] x);
    if (note) exp_q.push_back(x);
    core.issue(c, a, b, p, d);
  endtask
  // ***
  // tests
  // ***
  initial begin
    reset_n = 1'b0;
    void'($urandom(32'h3cc7_94ee));
    b = 3'($urandom);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (v[i]) begin
      v[i] = 8'($urandom);
      go(io_space_pkg::cmd_port_out, sa[i], '0, v[i], 0, '0);
    end
    foreach (v[i]) begin
      go(io_space_pkg::cmd_data_load, sa[i] + 8'h20, '0, '0, 1, v[i]);
      go(io_space_pkg::cmd_port_in, sa[i], '0, '0, 1, v[i]);
    end
    $display("test stores done");
    go(io_space_pkg::cmd_set_bit, 8'h1e, '0, '0, 0, '0);
    v[3][b] = 1'b1;
    go(io_space_pkg::cmd_test_bit, 8'h1e, 1'b1, '0, 1, 8'h01);
    go(io_space_pkg::cmd_test_bit, 8'h1e, 1'b0, '0, 1, 8'h00);
    go(io_space_pkg::cmd_clear_bit, 8'h1e, '0, '0, 0, '0);
    v[3][b] = 1'b0;
    go(io_space_pkg::cmd_test_bit, 8'h1e, 1'b0, '0, 1, 8'h01);
    go(io_space_pkg::cmd_port_in, 8'h1e, '0, '0, 1, v[3]);
    $display("test bits done");
    go(io_space_pkg::cmd_set_bit, 8'h3e, '0, '0, 0, '0);
    go(io_space_pkg::cmd_port_out, 8'h79, '0, 8'hff, 0, '0);
    go(io_space_pkg::cmd_port_in, 8'h7e, '0, '0, 1, 8'h00);
    go(io_space_pkg::cmd_data_store, 8'h19, '0, 8'hff, 0, '0);
    v[2] = ~v[2];
    go(io_space_pkg::cmd_data_store, 8'h3b, '0, v[2], 0, '0);
    go(io_space_pkg::cmd_data_load, 8'h80, '0, '0, 1, 8'ha0);
    foreach (v[i]) go(io_space_pkg::cmd_port_in, sa[i], '0, '0, 1, v[i]);
    $display("test refusals done");
    go(io_space_pkg::cmd_set_bit, 8'h1c, '0, '0, 0, '0);
    go(io_space_pkg::cmd_clear_bit, 8'h1c, '0, '0, 0, '0);
    go(io_space_pkg::cmd_data_load, 8'h45, '0, '0, 1, 8'ha5);
    go(io_space_pkg::cmd_data_store, 8'h88, '0, v[0], 0, '0);
    go(io_space_pkg::cmd_test_bit, 8'h05, 1'b1, '0, 1, 8'(8'ha5 >> b) & 8'h01);
    core.idle();
    repeat (3) @(posedge clk);
    $display("test peripherals done");
    `check("queue", 0, exp_q.size())
    wrap_up();
  end
endmodule // io_space_address_decode_bench
